/* tb/digipot_control_registers_test.sv */
// self-checking bench of the digipot control register bank
`timescale 1ns/1ps
module digipot_control_registers_test;
   logic clock, resetn, reg_wr, reg_rd, eeprom_busy_flag, device_locked;
   logic drv, pd, hz, iref;
   logic [7:0] reg_addr, wiper_code;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [3:0] gain_x2;
   logic [3:0] gt [4] = '{4'h3, 4'h4, 4'h6, 4'h8};
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////////////////////
   dpctl_regs dpctl_regs_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .eeprom_busy_flag(eeprom_busy_flag), .device_locked(device_locked),
      .wiper_code(wiper_code), .out_drive_en(drv), .out_pulldown_10k(pd), .out_high_z(hz),
      .int_ref_enable(iref), .gain_x2(gain_x2));
   dpctl_host_model dpctl_host_model_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         $display("Error run length expected done seen hang");
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      dpctl_host_model_i.wr(a, d);
   endtask
   task automatic rdc(input string name, input logic [7:0] a, input logic [15:0] exp);
      dpctl_host_model_i.rd(a, rv);
      cmp(name, exp, rv);
   endtask
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   task automatic outs(input logic [7:0] w, input logic [2:0] m, input logic ir,
      input logic [3:0] g);
      cmp("wiper_code", {8'h00, w}, {8'h00, wiper_code});
      cmp("out_mode", {13'h0000, m}, {13'h0000, drv, pd, hz});
      cmp("int_ref", {15'h0000, ir}, {15'h0000, iref});
      cmp("gain_x2", {12'h000, g}, {12'h000, gain_x2});
   endtask
   // host waits for the busy flag to fall before writing again
   task automatic nvm_run(input string name, input int lo, input int hi);
      int n;
      n = 0;
      repeat (4) @(posedge clock);
      #1;
      cmp(name, 16'h0001, {15'h0000, eeprom_busy_flag});
      rdc("status", dpctl_pkg::ADDR_STATUS, 16'h2000);
      while (eeprom_busy_flag === 1'b1 && n < 1000) begin
         @(posedge clock);
         #1;
         n++;
      end
      cmp(name, 16'h0000, {15'h0000, eeprom_busy_flag});
      cmp(name, 16'h0001, {15'h0000, n >= lo && n <= hi});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      outs(8'h00, 3'b001, 1'b0, 4'h2);
      rdc("setup", 8'hd1, 16'h01f0);
      rdc("control", 8'hd3, 16'h0008);
      rdc("wiper", 8'h21, 16'h0000);
      rdc("user", 8'h25, 16'h0000);
   endtask
   task automatic t_wiper();
      wr(8'h21, 16'h0940);
      settle();
      cmp("wiper_code", 16'h0094, {8'h00, wiper_code});
      rdc("wiper", 8'h21, 16'h0940);
      wr(8'h25, 16'h0ab0);
      rdc("user", 8'h25, 16'h0ab0);
      wr(8'h30, 16'hffff);
      rdc("unmapped", 8'h30, 16'h0000);
   endtask
   task automatic t_setup();
      logic [4:0] v;
      for (int i = 0; i < 32; i++) begin
         v = i[4:0];
         wr(8'hd1, 16'h01e0 | {11'h000, v});
         settle();
         outs(8'h94, {v[4:3] == 2'h0, v[3], v[4:3] == 2'h2}, v[2],
            v[2] ? gt[v[1:0]] : 4'h2);
         rdc("setup", 8'hd1, 16'h01e0 | {11'h000, v});
      end
   endtask
   task automatic t_lock();
      wr(8'hd1, 16'h01e5);
      wr(8'hd1, 16'h21e5);
      settle();
      cmp("locked", 16'h0001, {15'h0000, device_locked});
      wr(8'h21, 16'h0550);
      wr(8'hd1, 16'h01f0);
      wr(8'h25, 16'h0cc0);
      settle();
      cmp("wiper_code", 16'h0094, {8'h00, wiper_code});
      rdc("setup", 8'hd1, 16'h01e5);
      rdc("user", 8'h25, 16'h0ab0);
      wr(8'hd3, 16'h3018);
      settle();
      cmp("locked", 16'h0001, {15'h0000, device_locked});
      cmp("busy", 16'h0000, {15'h0000, eeprom_busy_flag});
      wr(8'hd3, 16'h5008);
      settle();
      cmp("locked", 16'h0000, {15'h0000, device_locked});
   endtask
   task automatic t_nvm();
      wr(8'hd3, 16'h0018);
      wr(8'h21, 16'h0110);
      nvm_run("store", dpctl_pkg::STORE_CYC - 10, dpctl_pkg::STORE_CYC + 5);
      rdc("control", 8'hd3, 16'h0008);
      cmp("wiper_code", 16'h0094, {8'h00, wiper_code});
      wr(8'h21, 16'h0110);
      wr(8'hd1, 16'h01f0);
      wr(8'h25, 16'h0000);
      settle();
      cmp("wiper_code", 16'h0011, {8'h00, wiper_code});
      wr(8'hd3, 16'h0028);
      nvm_run("recall", dpctl_pkg::RECALL_CYC - 10, dpctl_pkg::RECALL_CYC + 5);
      settle();
      outs(8'h94, 3'b100, 1'b1, 4'h4);
      rdc("user", 8'h25, 16'h0ab0);
      rdc("control", 8'hd3, 16'h0008);
   endtask
   task automatic t_soft();
      wr(8'h21, 16'h0220);
      wr(8'hd1, 16'h01f0);
      wr(8'hd3, 16'h000a);
      nvm_run("soft", dpctl_pkg::RECALL_CYC - 10, dpctl_pkg::RECALL_CYC + 5);
      settle();
      outs(8'h94, 3'b100, 1'b1, 4'h4);
      rdc("control", 8'hd3, 16'h0008);
   endtask
   task automatic t_factory();
      wr(8'hd1, 16'h21e5);
      wr(8'hd3, 16'h5200);
      settle();
      cmp("locked", 16'h0000, {15'h0000, device_locked});
      outs(8'h00, 3'b001, 1'b0, 4'h2);
      rdc("setup", 8'hd1, 16'h01f0);
      rdc("wiper", 8'h21, 16'h0000);
      rdc("user", 8'h25, 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      repeat (4) @(posedge clock);
      #1;
      resetn = 1'b1;
      t_reset();
      t_wiper();
      t_setup();
      t_lock();
      t_nvm();
      t_soft();
      t_factory();
      results();
   end
endmodule

/* tb/dpctl_host_model.sv */
// host side model that issues register reads and writes by command byte
`timescale 1ns/1ps
module dpctl_host_model (
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [15:0] reg_wdata,
   output logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end
   // one write strobe; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
      // an idle edge keeps two back-to-back strobes apart
      @(posedge clock);
      #1;
   endtask
   // one read strobe; data taken once the registered answer has landed
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge clock);
      #1;
      d = reg_rdata;
   endtask
endmodule

/* verilog/dpctl_link_if.sv */
// link between the register bank, the nonvolatile store and the output decoder
`timescale 1ns/1ps
interface dpctl_link_if;
   dpctl_pkg::dpctl_pot_t live;
   dpctl_pkg::dpctl_pot_t load_data;
   logic store_req;
   logic recall_req;
   logic busy;
   logic load_valid;
   modport ctl (output live, store_req, recall_req, input busy, load_valid, load_data);
   modport nvm (input live, store_req, recall_req, output busy, load_valid, load_data);
   modport dec (input live);
endinterface

/* verilog/dpctl_nvm.sv */
// nonvolatile copy of the potentiometer settings with timed store and recall
`timescale 1ns/1ps
module dpctl_nvm (
   input wire logic clock,
   input wire logic resetn,
   dpctl_link_if.nvm lnk
);
   dpctl_pkg::dpctl_nvst_t state_ff;
   dpctl_pkg::dpctl_nvst_t nxt_state;
   logic [9:0] cnt_ff;
   logic [9:0] nxt_cnt;
   dpctl_pkg::dpctl_pot_t cells_ff;
   dpctl_pkg::dpctl_pot_t pend_ff;
   dpctl_pkg::dpctl_pot_t data_ff;
   logic busy_ff;
   logic valid_ff;
   wire logic cnt_end = (cnt_ff == 10'h000);
   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff - 10'h001;
      case (state_ff)
         dpctl_pkg::NV_IDLE: begin
            nxt_cnt = cnt_ff;
            if (lnk.recall_req) begin
               nxt_state = dpctl_pkg::NV_RECALL;
               nxt_cnt = 10'(dpctl_pkg::RECALL_CYC - 1);
            end else if (lnk.store_req) begin
               nxt_state = dpctl_pkg::NV_STORE;
               nxt_cnt = 10'(dpctl_pkg::STORE_CYC - 1);
            end
         end
         dpctl_pkg::NV_STORE, dpctl_pkg::NV_RECALL: begin
            if (cnt_end) begin
               nxt_state = dpctl_pkg::NV_DONE;
            end
         end
         default: begin
            nxt_state = dpctl_pkg::NV_IDLE;
            nxt_cnt = cnt_ff;
         end
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_ff <= dpctl_pkg::NV_IDLE;
         cnt_ff <= 10'h000;
         busy_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         busy_ff <= (nxt_state != dpctl_pkg::NV_IDLE);
         valid_ff <= (state_ff == dpctl_pkg::NV_RECALL) && cnt_end;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cells_ff <= dpctl_pkg::POT_FACTORY;
         pend_ff <= dpctl_pkg::POT_FACTORY;
         data_ff <= dpctl_pkg::POT_FACTORY;
      end else begin
         if (state_ff == dpctl_pkg::NV_IDLE && lnk.store_req) begin
            pend_ff <= lnk.live;
         end
         if (state_ff == dpctl_pkg::NV_STORE && cnt_end) begin
            cells_ff <= pend_ff;
         end
         if (state_ff == dpctl_pkg::NV_RECALL && cnt_end) begin
            data_ff <= cells_ff;
         end
      end
   end
   assign lnk.busy = busy_ff;
   assign lnk.load_valid = valid_ff;
   assign lnk.load_data = data_ff;
   ////////////////////////////////////////////////////////////////////////////
   recall_data_a: assert property (@(posedge clock) disable iff (!resetn)
      valid_ff |-> data_ff == cells_ff && busy_ff) else $error("recall data not nvm");
   store_time_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_ff == dpctl_pkg::NV_IDLE && lnk.store_req && !lnk.recall_req)
      |=> busy_ff [*8] ##[490:500] !busy_ff) else $error("store busy time wrong");
endmodule

/* verilog/dpctl_outdec.sv */
// decode of the live settings into the analog control levels
`timescale 1ns/1ps
module dpctl_outdec (
   input wire logic clock,
   input wire logic resetn,
   dpctl_link_if.dec lnk,
   output logic [7:0] wiper_code,
   output logic out_drive_en,
   output logic out_pulldown_10k,
   output logic out_high_z,
   output logic int_ref_enable,
   output logic [3:0] gain_x2
);
   logic [3:0] span_gain;
   always_comb begin
      case (lnk.live.span)
         2'h0: span_gain = 4'h3;
         2'h1: span_gain = 4'h4;
         2'h2: span_gain = 4'h6;
         default: span_gain = 4'h8;
      endcase
   end
   wire logic [3:0] nxt_gain = lnk.live.ref_en ? span_gain : dpctl_pkg::GAIN_X2_UNITY;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wiper_code <= dpctl_pkg::POT_FACTORY.wiper;
         out_drive_en <= 1'b0;
         out_pulldown_10k <= 1'b0;
         out_high_z <= 1'b1;
         int_ref_enable <= 1'b0;
         gain_x2 <= dpctl_pkg::GAIN_X2_UNITY;
      end else begin
         wiper_code <= lnk.live.wiper;
         out_drive_en <= (lnk.live.pdn == dpctl_pkg::PDN_UP);
         out_pulldown_10k <= lnk.live.pdn[0];
         out_high_z <= (lnk.live.pdn == dpctl_pkg::PDN_HIZ);
         int_ref_enable <= lnk.live.ref_en;
         gain_x2 <= nxt_gain;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   pdn_decode_a: assert property (@(posedge clock) disable iff (!resetn)
      lnk.live.pdn == 2'h1 |=> out_pulldown_10k && !out_drive_en && !out_high_z)
      else $error("pulldown mode not decoded");
   gain_gate_a: assert property (@(posedge clock) disable iff (!resetn)
      !lnk.live.ref_en |=> gain_x2 == 4'h2) else $error("gain active without int ref");
endmodule

/* verilog/dpctl_pkg.sv */
// shared constants and types of the digipot control register bank
package dpctl_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // command byte addresses
   localparam logic [7:0] ADDR_STATUS = 8'hd0;
   localparam logic [7:0] ADDR_OUTPUT_SETUP = 8'hd1;
   localparam logic [7:0] ADDR_LOCK_NVM = 8'hd3;
   localparam logic [7:0] ADDR_WIPER = 8'h21;
   localparam logic [7:0] ADDR_USER_A = 8'h25;
   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] RST_OUTPUT_SETUP = 16'h01f0;
   localparam logic [15:0] RST_LOCK_NVM = 16'h0008;
   localparam logic [15:0] RST_WIPER = 16'h0000;
   localparam logic [15:0] RST_USER_A = 16'h0000;
   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int LOCK_BIT = 13;
   localparam int SETUP_FIXED_LSB = 5;
   localparam int PDN_LSB = 3;
   localparam int REF_BIT = 2;
   localparam int SPAN_LSB = 0;
   localparam int KEY_LSB = 12;
   localparam int CFG_RST_BIT = 9;
   localparam int RECALL_BIT = 5;
   localparam int STORE_BIT = 4;
   localparam int SWRST_LSB = 0;
   localparam int CODE_LSB = 2;
   localparam int BUSY_BIT = 13;
   ////////////////////////////////////////////////////////////////////////////
   // keys and codes
   localparam logic [7:0] SETUP_FIXED = 8'h0f;
   localparam logic [3:0] UNLOCK_KEY = 4'h5;
   localparam logic [3:0] SWRST_IDLE = 4'h8;
   localparam logic [3:0] SWRST_GO = 4'ha;
   localparam logic [1:0] PDN_UP = 2'h0;
   localparam logic [1:0] PDN_HIZ = 2'h2;
   localparam logic [3:0] GAIN_X2_UNITY = 4'h2;
   localparam int INT_REF_MV = 1210;
   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int STORE_TIME_NS = 20000;
   localparam int RECALL_TIME_NS = 2000;
   localparam int STORE_CYC = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECALL_CYC = (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [1:0] pdn;
      logic ref_en;
      logic [1:0] span;
      logic [7:0] wiper;
      logic [7:0] user;
   } dpctl_pot_t;
   localparam dpctl_pot_t POT_FACTORY = {RST_OUTPUT_SETUP[4:0], RST_WIPER[9:2],
      RST_USER_A[9:2]};
   typedef enum logic [1:0] {
      NV_IDLE = 2'b00,
      NV_STORE = 2'b01,
      NV_RECALL = 2'b10,
      NV_DONE = 2'b11
   } dpctl_nvst_t;
endpackage

/* verilog/dpctl_regs.sv */
// register bank of the buffered-wiper digital potentiometer
`timescale 1ns/1ps
module dpctl_regs (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic eeprom_busy_flag,
   output logic device_locked,
   output logic [7:0] wiper_code,
   output logic out_drive_en,
   output logic out_pulldown_10k,
   output logic out_high_z,
   output logic int_ref_enable,
   output logic [3:0] gain_x2
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   dpctl_link_if lnk ();
   logic [1:0] output_power_down_mode_ff;
   logic ref_sel_ff;
   logic [1:0] span_ff;
   logic [7:0] wiper_ff;
   logic [7:0] user_ff;
   logic lock_ff;
   logic store_cmd_ff;
   logic recall_cmd_ff;
   logic [15:0] rdata_ff;
   dpctl_pkg::dpctl_pot_t pot_now;
   dpctl_pkg::dpctl_pot_t nxt_pot;
   logic nxt_lock;
   ////////////////////////////////////////////////////////////////////////////
   // decode
   function automatic logic [7:0] code_field(input logic [15:0] w);
      code_field = w[dpctl_pkg::CODE_LSB + 2 +: 8];
   endfunction
   function automatic logic [15:0] code_word(input logic [7:0] c);
      code_word = {4'h0, c, 4'h0};
   endfunction
   wire logic hit_setup = reg_wr && (reg_addr == dpctl_pkg::ADDR_OUTPUT_SETUP);
   wire logic hit_ctl = reg_wr && (reg_addr == dpctl_pkg::ADDR_LOCK_NVM);
   wire logic hit_wiper = reg_wr && (reg_addr == dpctl_pkg::ADDR_WIPER);
   wire logic hit_user = reg_wr && (reg_addr == dpctl_pkg::ADDR_USER_A);
   wire logic key_ok = (reg_wdata[dpctl_pkg::KEY_LSB +: 4] == dpctl_pkg::UNLOCK_KEY);
   wire logic busy_any = lnk.busy || store_cmd_ff || recall_cmd_ff;
   wire logic pot_open = !lock_ff && !busy_any;
   wire logic wr_setup = hit_setup && pot_open;
   wire logic wr_wiper = hit_wiper && pot_open;
   wire logic wr_user = hit_user && pot_open;
   wire logic wr_ctl = hit_ctl && (!lock_ff || key_ok);
   wire logic do_unlock = wr_ctl && key_ok;
   wire logic ctl_cmd = wr_ctl && !busy_any;
   wire logic cfg_rst = ctl_cmd && reg_wdata[dpctl_pkg::CFG_RST_BIT];
   wire logic sw_rst = ctl_cmd && !cfg_rst &&
      (reg_wdata[dpctl_pkg::SWRST_LSB +: 4] == dpctl_pkg::SWRST_GO);
   wire logic recall_go = (ctl_cmd && !cfg_rst && reg_wdata[dpctl_pkg::RECALL_BIT]) || sw_rst;
   wire logic store_go = ctl_cmd && !cfg_rst && !recall_go && reg_wdata[dpctl_pkg::STORE_BIT];
   wire logic lock_go = wr_setup && reg_wdata[dpctl_pkg::LOCK_BIT];
   assign pot_now = {output_power_down_mode_ff, ref_sel_ff, span_ff, wiper_ff, user_ff};
   ////////////////////////////////////////////////////////////////////////////
   // next state of the potentiometer settings and lock
   always_comb begin
      nxt_pot = pot_now;
      if (lnk.load_valid) begin
         nxt_pot = lnk.load_data;
      end else if (cfg_rst || sw_rst) begin
         nxt_pot = dpctl_pkg::POT_FACTORY;
      end else begin
         if (wr_setup) begin
            nxt_pot.pdn = reg_wdata[dpctl_pkg::PDN_LSB +: 2];
            nxt_pot.ref_en = reg_wdata[dpctl_pkg::REF_BIT];
            nxt_pot.span = reg_wdata[dpctl_pkg::SPAN_LSB +: 2];
         end
         if (wr_wiper) begin
            nxt_pot.wiper = code_field(reg_wdata);
         end
         if (wr_user) begin
            nxt_pot.user = code_field(reg_wdata);
         end
      end
   end
   assign nxt_lock = (cfg_rst || sw_rst || do_unlock) ? 1'b0 : (lock_ff || lock_go);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         output_power_down_mode_ff <= dpctl_pkg::POT_FACTORY.pdn;
         ref_sel_ff <= dpctl_pkg::POT_FACTORY.ref_en;
         span_ff <= dpctl_pkg::POT_FACTORY.span;
         wiper_ff <= dpctl_pkg::POT_FACTORY.wiper;
         user_ff <= dpctl_pkg::POT_FACTORY.user;
      end else begin
         output_power_down_mode_ff <= nxt_pot.pdn;
         ref_sel_ff <= nxt_pot.ref_en;
         span_ff <= nxt_pot.span;
         wiper_ff <= nxt_pot.wiper;
         user_ff <= nxt_pot.user;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lock_ff <= 1'b0;
         store_cmd_ff <= 1'b0;
         recall_cmd_ff <= 1'b0;
         device_locked <= 1'b0;
      end else begin
         lock_ff <= nxt_lock;
         device_locked <= nxt_lock;
         store_cmd_ff <= store_go || (store_cmd_ff && !lnk.busy);
         recall_cmd_ff <= recall_go || (recall_cmd_ff && !lnk.busy);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // read side
   wire logic [15:0] rd_setup = {2'b00, 1'b0, dpctl_pkg::SETUP_FIXED, output_power_down_mode_ff,
      ref_sel_ff, span_ff};
   wire logic [15:0] rd_ctl = {4'h0, 2'b00, 1'b0, 3'b000, recall_cmd_ff, store_cmd_ff,
      dpctl_pkg::SWRST_IDLE};
   wire logic [15:0] rd_status = 16'(lnk.busy) << dpctl_pkg::BUSY_BIT;
   logic [15:0] rd_val;
   always_comb begin
      case (reg_addr)
         dpctl_pkg::ADDR_STATUS: rd_val = rd_status;
         dpctl_pkg::ADDR_OUTPUT_SETUP: rd_val = rd_setup;
         dpctl_pkg::ADDR_LOCK_NVM: rd_val = rd_ctl;
         dpctl_pkg::ADDR_WIPER: rd_val = code_word(wiper_ff);
         dpctl_pkg::ADDR_USER_A: rd_val = code_word(user_ff);
         default: rd_val = 16'h0000;
      endcase
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         rdata_ff <= rd_val;
      end
   end
   assign reg_rdata = rdata_ff;
   ////////////////////////////////////////////////////////////////////////////
   // submodules
   assign lnk.live = pot_now;
   assign lnk.store_req = store_cmd_ff;
   assign lnk.recall_req = recall_cmd_ff;
   assign eeprom_busy_flag = lnk.busy;
   dpctl_nvm u_nvm (
      .clock(clock),
      .resetn(resetn),
      .lnk(lnk.nvm)
   );
   dpctl_outdec u_dec (
      .clock(clock),
      .resetn(resetn),
      .lnk(lnk.dec),
      .wiper_code(wiper_code),
      .out_drive_en(out_drive_en),
      .out_pulldown_10k(out_pulldown_10k),
      .out_high_z(out_high_z),
      .int_ref_enable(int_ref_enable),
      .gain_x2(gain_x2)
   );
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence wiper_seen_s;
      ##2 wiper_code == $past(reg_wdata[11:4], 2);
   endsequence
   sequence store_running_s;
      ##2 eeprom_busy_flag [*8];
   endsequence
   lock_set_a: assert property (lock_go && !cfg_rst |=> lock_ff)
      else $error("lock not set");
   unlock_key_a: assert property (hit_ctl && key_ok |=> !lock_ff && !device_locked)
      else $error("unlock key ignored");
   locked_wiper_a: assert property (lock_ff && hit_wiper && !lnk.load_valid
      |=> $stable(wiper_ff)) else $error("locked wiper changed");
   busy_wiper_a: assert property (busy_any && hit_wiper && !lnk.load_valid
      |=> $stable(wiper_ff)) else $error("wiper written while busy");
   wiper_apply_a: assert property (wr_wiper |-> wiper_seen_s)
      else $error("wiper code not applied");
   store_busy_a: assert property (store_go |-> store_running_s)
      else $error("store did not raise busy");
   self_clear_a: assert property (store_go || recall_go |-> ##[2:3] !store_cmd_ff
      && !recall_cmd_ff) else $error("command bit not cleared");
   busy_end_a: assert property ($rose(eeprom_busy_flag) |-> ##[1:600] !eeprom_busy_flag)
      else $error("busy never clears");
   factory_a: assert property (cfg_rst && !lnk.load_valid |=> pot_now ==
      dpctl_pkg::POT_FACTORY && !lock_ff) else $error("factory restore failed");
   soft_reset_a: assert property (sw_rst |=> recall_cmd_ff && !lock_ff)
      else $error("soft reset did not recall");
   ctl_read_a: assert property (reg_rd && reg_addr == dpctl_pkg::ADDR_LOCK_NVM
      |=> reg_rdata[3:0] == 4'h8) else $error("soft reset key not at rest");
   recall_load_a: assert property (recall_go |-> ##[50:60] lnk.load_valid)
      else $error("recall data not loaded");
endmodule
